/* mpcr_pkg.sv */
package mpcr_pkg;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_ACT_A     = 16'he513;
    localparam logic [15:0] IDX_ACT_B     = 16'he514;
    localparam logic [15:0] IDX_ACT_C     = 16'he515;
    localparam logic [15:0] IDX_REA_A     = 16'he516;
    localparam logic [15:0] IDX_REA_B     = 16'he517;
    localparam logic [15:0] IDX_REA_C     = 16'he518;
    localparam logic [15:0] IDX_APP_A     = 16'he519;
    localparam logic [15:0] IDX_APP_B     = 16'he51a;
    localparam logic [15:0] IDX_APP_C     = 16'he51b;
    localparam logic [15:0] IDX_CHECKSUM  = 16'he51f;
    localparam logic [15:0] IDX_VNOMINAL  = 16'he520;
    localparam logic [15:0] IDX_PEAK_STAT = 16'he600;
    localparam logic [15:0] IDX_DELAY_0   = 16'he601;
    localparam logic [15:0] IDX_DELAY_1   = 16'he602;
    localparam logic [15:0] IDX_DELAY_2   = 16'he603;
    localparam logic [15:0] IDX_PERIOD    = 16'he607;
    localparam logic [15:0] IDX_NOLOAD    = 16'he608;
    localparam logic [15:0] IDX_LINE_CYCLE_COUNT   = 16'he60c;
    localparam logic [15:0] IDX_ZX_TMO    = 16'he60d;
    localparam logic [15:0] IDX_COMP_MODE = 16'he60e;
    localparam logic [15:0] IDX_GAIN_SEL  = 16'he60f;
    localparam logic [15:0] IDX_PULSE_CFG = 16'he610;
    localparam logic [15:0] IDX_PULSE1_DN = 16'he611;
    localparam logic [15:0] IDX_PULSE2_DN = 16'he612;
    localparam logic [15:0] IDX_PULSE3_DN = 16'he613;
    localparam logic [15:0] IDX_PHCAL_A   = 16'he614;
    localparam logic [15:0] IDX_PHCAL_B   = 16'he615;

    // ==========================================================
    // Widths and reset values
    localparam int          PWR_W   = 24;
    localparam int          HALF_W  = 16;
    localparam int          CAL_W   = 10;
    localparam logic [31:0] RST_CHECKSUM  = 32'h3366_6787;
    localparam logic [23:0] RST_VNOMINAL  = 24'h00_0000;
    localparam logic [15:0] RST_LINE_CYCLE_COUNT   = 16'hffff;
    localparam logic [15:0] RST_ZX_TMO    = 16'hffff;
    localparam logic [15:0] RST_COMP_MODE = 16'h01ff;
    localparam logic [15:0] RST_GAIN_SEL  = 16'h0000;
    localparam logic [15:0] RST_PULSE_CFG = 16'h0e88;
    localparam logic [15:0] RST_PULSE_DN  = 16'h0000;
    localparam logic [9:0]  RST_PHCAL     = 10'h000;

    // ==========================================================
    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* mpcr_regs.sv */
`timescale 1ns/100ps
// How it works
// R1 - Three read-only signed 24-bit active power words, read sign-extended to 32 bits.
// R2 - Three read-only signed 24-bit reactive power words, read sign-extended to 32 bits.
// R3 - Three read-only signed 24-bit apparent power words, read sign-extended to 32 bits.
// R4 - Read-only 32-bit checksum word, reset value 0x33666787.
// R5 - Writable 24-bit nominal voltage, reset zero, read zero-padded, drives the apparent path.
// R6 - Host never writes reserved addresses; here such writes are answered with an error.
// R7 - Three read-only 16-bit phase delay words and a 16-bit line period word.
// R8 - Read-only 16-bit peak status and no-load status, no defined reset value.
// R9 - Writable 16-bit line-cycle count and zero-crossing timeout, reset to all ones.
// R10 - Writable 16-bit computation-mode word, reset 0x01FF.
// R11 - Writable 16-bit gain select word, reset zero.
// R12 - Writable pulse config reset 0x0E88 and three pulse denominators reset zero.
// R13 - Writable 10-bit phase calibration for phases A and B, reset zero, read as 16 bits.
// R14 - Sign-extended words replicate bit 23 into the upper byte.
// R15 - Zero-padded 24-bit words read with upper byte cleared.
// R16 - 10-bit words read with six upper bits of the 16-bit word cleared.
// R17 - Writes to read-only words change nothing.
module mpcr_regs
    import mpcr_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [PWR_W-1:0]    active_power_a,
    input  wire logic [PWR_W-1:0]    active_power_b,
    input  wire logic [PWR_W-1:0]    active_power_c,
    input  wire logic [PWR_W-1:0]    reactive_power_a,
    input  wire logic [PWR_W-1:0]    reactive_power_b,
    input  wire logic [PWR_W-1:0]    reactive_power_c,
    input  wire logic [PWR_W-1:0]    apparent_power_a,
    input  wire logic [PWR_W-1:0]    apparent_power_b,
    input  wire logic [PWR_W-1:0]    apparent_power_c,
    input  wire logic [31:0]         checksum_value,
    input  wire logic [HALF_W-1:0]   peak_status_in,
    input  wire logic [HALF_W-1:0]   delay_0_in,
    input  wire logic [HALF_W-1:0]   delay_1_in,
    input  wire logic [HALF_W-1:0]   delay_2_in,
    input  wire logic [HALF_W-1:0]   period_in,
    input  wire logic [HALF_W-1:0]   noload_status_in,
    output logic [PWR_W-1:0]         nominal_voltage_rms,
    output logic [HALF_W-1:0]        line_cycle_count,
    output logic [HALF_W-1:0]        zero_cross_timeout,
    output logic [HALF_W-1:0]        computation_mode,
    output logic [HALF_W-1:0]        input_gain_select,
    output logic [HALF_W-1:0]        pulse_output_config,
    output logic [HALF_W-1:0]        pulse1_denominator,
    output logic [HALF_W-1:0]        pulse2_denominator,
    output logic [HALF_W-1:0]        pulse3_denominator,
    output logic [CAL_W-1:0]         phase_cal_a,
    output logic [CAL_W-1:0]         phase_cal_b
);

    // ==========================================================
    // Transfer formatting
    function automatic logic [31:0] sign_extended_transfer(input logic [23:0] v);
        return {{8{v[23]}}, v};
    endfunction

    function automatic logic [31:0] zero_padded_transfer_wide(input logic [23:0] v);
        return {8'h00, v};
    endfunction

    function automatic logic [31:0] zero_padded_transfer_narrow(input logic [9:0] v);
        return {16'h0000, 6'h00, v};
    endfunction

    function automatic logic [15:0] word_index(input logic [ADDR_W-1:0] a);
        return a[17:2];
    endfunction

    // Byte-lane merge for 16-bit words
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Same merge for the 10-bit calibration words; upper lane bits are dropped
    function automatic logic [CAL_W-1:0] merge10(input logic [CAL_W-1:0] old, input logic [31:0] d,
                                                input logic [3:0] s);
        return {s[1] ? d[9:8] : old[9:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ==========================================================
    // Write channel: address and data latched in either order
    logic              aw_held;
    logic              w_held;
    logic [15:0]       aw_idx;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              wr_fire;
    logic              wr_known;
    logic              wr_writable;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            aw_held <= 1'b0;
            aw_idx  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx  <= word_index(s_axi_awaddr);
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_comb begin
        wr_writable = 1'b1;
        if (aw_idx == IDX_VNOMINAL) wr_writable = 1'b1;
        else if (aw_idx >= IDX_LINE_CYCLE_COUNT && aw_idx <= IDX_PHCAL_B) wr_writable = 1'b1;
        else wr_writable = 1'b0;
    end

    always_comb begin
        wr_known = 1'b1;
        if (aw_idx >= IDX_ACT_A && aw_idx <= IDX_APP_C) wr_known = 1'b1;
        else if (aw_idx >= IDX_CHECKSUM && aw_idx <= IDX_VNOMINAL) wr_known = 1'b1;
        else if (aw_idx >= IDX_PEAK_STAT && aw_idx <= IDX_DELAY_2) wr_known = 1'b1;
        else if (aw_idx >= IDX_PERIOD && aw_idx <= IDX_NOLOAD) wr_known = 1'b1;
        else if (aw_idx >= IDX_LINE_CYCLE_COUNT && aw_idx <= IDX_PHCAL_B) wr_known = 1'b1;
        else wr_known = 1'b0;
    end

    // Read-only words accept the write with OKAY and keep their value
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR; // R6 R17
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Writable configuration words
    always_ff @(posedge core_clk) begin
        if (reset) begin
            nominal_voltage_rms <= RST_VNOMINAL; // R5
            line_cycle_count    <= RST_LINE_CYCLE_COUNT; // R9
            zero_cross_timeout  <= RST_ZX_TMO; // R9
            computation_mode    <= RST_COMP_MODE; // R10
            input_gain_select   <= RST_GAIN_SEL; // R11
            pulse_output_config <= RST_PULSE_CFG; // R12
            pulse1_denominator  <= RST_PULSE_DN; // R12
            pulse2_denominator  <= RST_PULSE_DN;
            pulse3_denominator  <= RST_PULSE_DN;
            phase_cal_a         <= RST_PHCAL; // R13
            phase_cal_b         <= RST_PHCAL;
        end else if (wr_fire && wr_writable) begin // R17
            if (aw_idx == IDX_VNOMINAL) begin
                nominal_voltage_rms <= {w_strb[2] ? w_data[23:16] : nominal_voltage_rms[23:16],
                                        merge16(nominal_voltage_rms[15:0], w_data, w_strb)}; // R5
            end else if (aw_idx == IDX_LINE_CYCLE_COUNT) begin
                line_cycle_count <= merge16(line_cycle_count, w_data, w_strb); // R9
            end else if (aw_idx == IDX_ZX_TMO) begin
                zero_cross_timeout <= merge16(zero_cross_timeout, w_data, w_strb); // R9
            end else if (aw_idx == IDX_COMP_MODE) begin
                computation_mode <= merge16(computation_mode, w_data, w_strb); // R10
            end else if (aw_idx == IDX_GAIN_SEL) begin
                input_gain_select <= merge16(input_gain_select, w_data, w_strb); // R11
            end else if (aw_idx == IDX_PULSE_CFG) begin
                pulse_output_config <= merge16(pulse_output_config, w_data, w_strb); // R12
            end else if (aw_idx == IDX_PULSE1_DN) begin
                pulse1_denominator <= merge16(pulse1_denominator, w_data, w_strb); // R12
            end else if (aw_idx == IDX_PULSE2_DN) begin
                pulse2_denominator <= merge16(pulse2_denominator, w_data, w_strb);
            end else if (aw_idx == IDX_PULSE3_DN) begin
                pulse3_denominator <= merge16(pulse3_denominator, w_data, w_strb);
            end else if (aw_idx == IDX_PHCAL_A) begin
                phase_cal_a <= merge10(phase_cal_a, w_data, w_strb); // R13
            end else if (aw_idx == IDX_PHCAL_B) begin
                phase_cal_b <= merge10(phase_cal_b, w_data, w_strb); // R13
            end
        end
    end

    // ==========================================================
    // Read channel: one-cycle registered answer
    logic [15:0] ar_idx;
    logic [31:0] next_rdata;
    logic        rd_known;

    assign s_axi_arready = !s_axi_rvalid;
    assign ar_idx        = word_index(s_axi_araddr);

    always_comb begin
        next_rdata = '0;
        rd_known   = 1'b1;
        if (ar_idx == IDX_ACT_A) next_rdata = sign_extended_transfer(active_power_a); // R1 R14
        else if (ar_idx == IDX_ACT_B) next_rdata = sign_extended_transfer(active_power_b); // R1
        else if (ar_idx == IDX_ACT_C) next_rdata = sign_extended_transfer(active_power_c); // R1
        else if (ar_idx == IDX_REA_A) next_rdata = sign_extended_transfer(reactive_power_a); // R2
        else if (ar_idx == IDX_REA_B) next_rdata = sign_extended_transfer(reactive_power_b); // R2
        else if (ar_idx == IDX_REA_C) next_rdata = sign_extended_transfer(reactive_power_c); // R2
        else if (ar_idx == IDX_APP_A) next_rdata = sign_extended_transfer(apparent_power_a); // R3
        else if (ar_idx == IDX_APP_B) next_rdata = sign_extended_transfer(apparent_power_b); // R3
        else if (ar_idx == IDX_APP_C) next_rdata = sign_extended_transfer(apparent_power_c); // R3
        else if (ar_idx == IDX_CHECKSUM) next_rdata = checksum_value; // R4
        else if (ar_idx == IDX_VNOMINAL) next_rdata = zero_padded_transfer_wide(nominal_voltage_rms); // R15
        else if (ar_idx == IDX_PEAK_STAT) next_rdata = {16'h0000, peak_status_in}; // R8
        else if (ar_idx == IDX_DELAY_0) next_rdata = {16'h0000, delay_0_in}; // R7
        else if (ar_idx == IDX_DELAY_1) next_rdata = {16'h0000, delay_1_in}; // R7
        else if (ar_idx == IDX_DELAY_2) next_rdata = {16'h0000, delay_2_in}; // R7
        else if (ar_idx == IDX_PERIOD) next_rdata = {16'h0000, period_in}; // R7
        else if (ar_idx == IDX_NOLOAD) next_rdata = {16'h0000, noload_status_in}; // R8
        else if (ar_idx == IDX_LINE_CYCLE_COUNT) next_rdata = {16'h0000, line_cycle_count};
        else if (ar_idx == IDX_ZX_TMO) next_rdata = {16'h0000, zero_cross_timeout};
        else if (ar_idx == IDX_COMP_MODE) next_rdata = {16'h0000, computation_mode};
        else if (ar_idx == IDX_GAIN_SEL) next_rdata = {16'h0000, input_gain_select};
        else if (ar_idx == IDX_PULSE_CFG) next_rdata = {16'h0000, pulse_output_config};
        else if (ar_idx == IDX_PULSE1_DN) next_rdata = {16'h0000, pulse1_denominator};
        else if (ar_idx == IDX_PULSE2_DN) next_rdata = {16'h0000, pulse2_denominator};
        else if (ar_idx == IDX_PULSE3_DN) next_rdata = {16'h0000, pulse3_denominator};
        else if (ar_idx == IDX_PHCAL_A) next_rdata = zero_padded_transfer_narrow(phase_cal_a); // R16
        else if (ar_idx == IDX_PHCAL_B) next_rdata = zero_padded_transfer_narrow(phase_cal_b); // R16
        else rd_known = 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    sequence s_ro_write;
        wr_fire && !wr_writable;
    endsequence

    property p_ro_untouched;
        @(posedge core_clk) disable iff (reset)
        s_ro_write |=> $stable(computation_mode) && $stable(nominal_voltage_rms) && $stable(phase_cal_a);
    endproperty
    a_ro_untouched: assert property (p_ro_untouched) else $error("read-only write changed a register"); // R17

    property p_sign_ext;
        @(posedge core_clk) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && ar_idx == IDX_ACT_A)
            |=> s_axi_rdata[31:24] == {8{$past(active_power_a[23])}};
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("active power not sign extended"); // R14

    property p_reactive;
        @(posedge core_clk) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && ar_idx == IDX_REA_B)
            |=> s_axi_rdata == {{8{$past(reactive_power_b[23])}}, $past(reactive_power_b)};
    endproperty
    a_reactive: assert property (p_reactive) else $error("reactive power read wrong"); // R2

    property p_apparent;
        @(posedge core_clk) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && ar_idx == IDX_APP_C)
            |=> s_axi_rdata[23:0] == $past(apparent_power_c) && s_axi_rresp == RESP_OKAY;
    endproperty
    a_apparent: assert property (p_apparent) else $error("apparent power read wrong"); // R3

    property p_nominal_voltage_rms_pad;
        @(posedge core_clk) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && ar_idx == IDX_VNOMINAL) |=> s_axi_rdata[31:24] == 8'h00;
    endproperty
    a_nominal_voltage_rms_pad: assert property (p_nominal_voltage_rms_pad) else $error("nominal voltage not zero padded"); // R15

    property p_cal_pad;
        @(posedge core_clk) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && ar_idx == IDX_PHCAL_B) |=> s_axi_rdata[31:10] == '0;
    endproperty
    a_cal_pad: assert property (p_cal_pad) else $error("phase calibration not zero padded"); // R16

    property p_reset_vals;
        @(posedge core_clk)
        $past(reset) |-> computation_mode == RST_COMP_MODE && pulse_output_config == RST_PULSE_CFG
            && line_cycle_count == RST_LINE_CYCLE_COUNT && zero_cross_timeout == RST_ZX_TMO;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("configuration reset value wrong"); // R10

    property p_reserved_err;
        @(posedge core_clk) disable iff (reset)
        (wr_fire && !wr_known) |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
    endproperty
    a_reserved_err: assert property (p_reserved_err) else $error("reserved write not flagged"); // R6

    property p_mode_write;
        @(posedge core_clk) disable iff (reset)
        (wr_fire && aw_idx == IDX_COMP_MODE && w_strb == 4'hf) |=> computation_mode == $past(w_data[15:0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("computation mode write lost"); // R10

    property p_pulse_cfg_write;
        @(posedge core_clk) disable iff (reset)
        (wr_fire && aw_idx == IDX_PULSE_CFG && w_strb == 4'hf) |=> pulse_output_config == $past(w_data[15:0]);
    endproperty
    a_pulse_cfg_write: assert property (p_pulse_cfg_write) else $error("pulse config write lost"); // R12

    property p_cal_write;
        @(posedge core_clk) disable iff (reset)
        (wr_fire && aw_idx == IDX_PHCAL_A && w_strb == 4'hf) |=> phase_cal_a == $past(w_data[9:0]);
    endproperty
    a_cal_write: assert property (p_cal_write) else $error("phase calibration write lost"); // R13

endmodule

/* test_metering_power_config_regs.sv */
`timescale 1ns/100ps
module test_metering_power_config_regs
    import mpcr_pkg::*;
();
    // ==========================================================
    // Tables of mapped words
    localparam logic [15:0] RW_IDX [11] = '{IDX_VNOMINAL, IDX_LINE_CYCLE_COUNT, IDX_ZX_TMO, IDX_COMP_MODE, IDX_GAIN_SEL,
        IDX_PULSE_CFG, IDX_PULSE1_DN, IDX_PULSE2_DN, IDX_PULSE3_DN, IDX_PHCAL_A, IDX_PHCAL_B};
    localparam logic [31:0] RW_RST [11] = '{{8'h00, RST_VNOMINAL}, {16'h0000, RST_LINE_CYCLE_COUNT}, {16'h0000, RST_ZX_TMO},
        {16'h0000, RST_COMP_MODE}, {16'h0000, RST_GAIN_SEL}, {16'h0000, RST_PULSE_CFG}, {16'h0000, RST_PULSE_DN},
        {16'h0000, RST_PULSE_DN}, {16'h0000, RST_PULSE_DN}, {22'h00_0000, RST_PHCAL}, {22'h00_0000, RST_PHCAL}};
    localparam logic [31:0] RW_MASK [11] = '{32'h00ff_ffff, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff,
        32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_03ff, 32'h0000_03ff};
    localparam logic [15:0] PW_IDX [9] = '{IDX_ACT_A, IDX_ACT_B, IDX_ACT_C, IDX_REA_A, IDX_REA_B, IDX_REA_C,
        IDX_APP_A, IDX_APP_B, IDX_APP_C};
    localparam logic [15:0] ST_IDX [6] = '{IDX_PEAK_STAT, IDX_DELAY_0, IDX_DELAY_1, IDX_DELAY_2, IDX_PERIOD,
        IDX_NOLOAD};
    // Reserved words are read; stray writes go to unmapped words, one of which (16'he616) is also read as reserved
    localparam logic [15:0] RSV_IDX [5] = '{16'he521, 16'he52e, 16'he604, 16'he609, 16'he616};
    localparam logic [15:0] UNM_IDX [5] = '{16'he51c, 16'he51d, 16'he51e, 16'he616, 16'he617};
    localparam logic [31:0] PATS [2] = '{32'hffff_ffff, 32'h5a5a_a5a5};

    logic        core_clk = 1'b0;
    logic        reset;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, resp;
    logic [23:0] pw [9];
    logic [15:0] st [6];
    logic [23:0] nv;
    logic [15:0] o16 [8];
    logic [9:0]  cal [2];
    logic [31:0] d;
    int          err_count = 0;
    int          compares = 0;

    always #4 core_clk = ~core_clk;

    mpcr_regs #(.ADDR_W(18)) uut (
        .core_clk(core_clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .active_power_a(pw[0]), .active_power_b(pw[1]), .active_power_c(pw[2]),
        .reactive_power_a(pw[3]), .reactive_power_b(pw[4]), .reactive_power_c(pw[5]),
        .apparent_power_a(pw[6]), .apparent_power_b(pw[7]), .apparent_power_c(pw[8]),
        .checksum_value(RST_CHECKSUM), .peak_status_in(st[0]), .delay_0_in(st[1]), .delay_1_in(st[2]),
        .delay_2_in(st[3]), .period_in(st[4]), .noload_status_in(st[5]), .nominal_voltage_rms(nv),
        .line_cycle_count(o16[0]), .zero_cross_timeout(o16[1]), .computation_mode(o16[2]),
        .input_gain_select(o16[3]), .pulse_output_config(o16[4]), .pulse1_denominator(o16[5]),
        .pulse2_denominator(o16[6]), .pulse3_denominator(o16[7]), .phase_cal_a(cal[0]), .phase_cal_b(cal[1])
    );

    // ==========================================================
    // Reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic give_up(input string msg);
        err_count++;
        $display("unexpected at %0t: no answer to %s", $time, msg);
        wrap_up();
    endtask

    // ==========================================================
    // Bus master; signals are driven by nonblocking assignment after the rising edge
    task automatic axi_write(input logic [15:0] idx, input logic [31:0] dat, output logic [1:0] rsp);
        int   n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= {idx, 2'b00};
        awvalid <= 1'b1;
        wdata <= dat;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge core_clk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
            n++;
            if (n > 50) give_up("write request");
        end
        do begin
            @(posedge core_clk);
            n++;
            if (n > 100) give_up("write response");
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic axi_read(input logic [15:0] idx, output logic [31:0] dat, output logic [1:0] rsp);
        int n;
        n = 0;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (n > 50) give_up("read request");
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
            if (n > 100) give_up("read response");
        end while (rvalid !== 1'b1);
        dat = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge core_clk);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        reset <= 1'b1;
        {awaddr, araddr, wdata, wstrb} <= '0;
        {awvalid, wvalid, bready, arvalid, rready} <= '0;
        for (int i = 0; i < 9; i++) pw[i] <= {i[0], 23'(i * 24'h0a_3c5d + 24'h00_1234)};
        for (int i = 0; i < 6; i++) st[i] <= 16'h8001 + 16'(i * 16'h1357);
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 11; i++) begin
            axi_read(RW_IDX[i], d, resp);
            check(d, RW_RST[i], "reset value");
        end
        axi_read(IDX_CHECKSUM, d, resp);
        check(d, RST_CHECKSUM, "checksum");
        for (int i = 0; i < 9; i++) begin
            axi_read(PW_IDX[i], d, resp);
            check(d, {{8{pw[i][23]}}, pw[i]}, "power word");
        end
        for (int i = 0; i < 6; i++) begin
            axi_read(ST_IDX[i], d, resp);
            check(d, {16'h0000, st[i]}, "status word");
        end
        // Writes to read-only words are accepted but ignored
        foreach (PW_IDX[i]) begin
            axi_write(PW_IDX[i], 32'h0000_0000, resp);
            check({30'h0, resp}, {30'h0, RESP_OKAY}, "ro write resp");
        end
        axi_write(IDX_CHECKSUM, 32'h0000_0000, resp);
        check({30'h0, resp}, {30'h0, RESP_OKAY}, "ro write resp");
        axi_write(IDX_DELAY_0, 32'h0000_0000, resp);
        check({30'h0, resp}, {30'h0, RESP_OKAY}, "ro write resp");
        axi_read(IDX_CHECKSUM, d, resp);
        check(d, RST_CHECKSUM, "checksum after write");
        axi_read(IDX_ACT_A, d, resp);
        check(d, {{8{pw[0][23]}}, pw[0]}, "power after write");
        axi_read(IDX_DELAY_0, d, resp);
        check(d, {16'h0000, st[1]}, "delay after write");
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 11; i++) axi_write(RW_IDX[i], PATS[p], resp);
            for (int i = 0; i < 11; i++) begin
                axi_read(RW_IDX[i], d, resp);
                check(d, PATS[p] & RW_MASK[i], "padded readback");
            end
        end
        check({8'h00, nv}, 32'h005a_a5a5, "voltage output");
        check({16'h0000, o16[2]}, 32'h0000_a5a5, "mode output");
        check({22'h00_0000, cal[1]}, 32'h0000_01a5, "cal output");
        for (int i = 0; i < 8; i++) check({16'h0000, o16[i]}, 32'h0000_a5a5, "config output");
        check({22'h00_0000, cal[0]}, 32'h0000_01a5, "cal output");
        foreach (RSV_IDX[i]) begin
            axi_write(UNM_IDX[i], 32'hffff_ffff, resp);
            check({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
            axi_read(RSV_IDX[i], d, resp);
            check({d[31:2], resp}, {30'h0, RESP_SLVERR}, "reserved read");
        end
        for (int i = 0; i < 11; i++) begin
            axi_read(RW_IDX[i], d, resp);
            check(d, PATS[1] & RW_MASK[i], "undisturbed");
        end
        wrap_up();
    end
endmodule
